/* design/pscs_consts.svh */
// Offsets, field positions, reset values and timing counts
`ifndef PSCS_CONSTS_SVH
`define PSCS_CONSTS_SVH

`define PSCS_CLK_MHZ 50
`define PSCS_POR_STD_MIN_MS 100
`define PSCS_POR_STD_MAX_MS 300
`define PSCS_POR_FAST_MIN_MS 4
`define PSCS_POR_FAST_MAX_MS 12
`define PSCS_POR_STD_CYCLES \
    ((`PSCS_POR_STD_MIN_MS + `PSCS_POR_STD_MAX_MS) / 2 * 1000 * `PSCS_CLK_MHZ)
`define PSCS_POR_FAST_CYCLES \
    ((`PSCS_POR_FAST_MIN_MS + `PSCS_POR_FAST_MAX_MS) / 2 * 1000 * `PSCS_CLK_MHZ)
`define PSCS_INIT_MIN_US 55
`define PSCS_INIT_CYCLES (`PSCS_INIT_MIN_US * `PSCS_CLK_MHZ)
`define PSCS_USR_EDGES 8532

`define PSCS_OFS_CTRL 8'h00
`define PSCS_OFS_IMAGE 8'h04
`define PSCS_OFS_STATUS 8'h08
`define PSCS_CTRL_CABLE 0
`define PSCS_CTRL_USRCLK 1
`define PSCS_CTRL_RST 32'h0000_0001
`define PSCS_IMAGE_RST 32'h0000_1000
`define PSCS_STAT_ERR 8

`define PSCS_PREAMBLE 8'ha5
`define PSCS_HDR_BITS 32'h0000_0008

`endif

/* design/pscs_pkg.sv */
// Types shared by the configuration slave modules
package pscs_pkg;
    typedef enum logic [5:0] {
        ST_POR = 6'h01,
        ST_RESET = 6'h02,
        ST_CONFIG = 6'h04,
        ST_INIT = 6'h08,
        ST_USER = 6'h10,
        ST_ERROR = 6'h20
    } pscs_state_t;
endpackage

/* design/pscs_link_if.sv */
// Signals between the stage controller and the shift-clock loader
`timescale 1ns/1ps
interface pscs_link_if;
    logic clear_n;
    logic [31:0] image_bits;
    logic done;
    logic err;
    modport main (output clear_n, output image_bits, input done, input err);
    modport link (input clear_n, input image_bits, output done, output err);
endinterface

/* design/pscs_shift.sv */
// Loader running on the configuration shift clock
`timescale 1ns/1ps
`include "pscs_consts.svh"
module pscs_shift
    import pscs_pkg::*;
(
    // Link clock and data
    input wire logic clk,
    input wire logic din,
    // Controller side
    pscs_link_if.link lnk
);
    logic [7:0] hdr_ff;
    logic [31:0] cnt_ff;
    logic done_ff;
    logic err_ff;
    logic run;

    // Clear is released at least 2 us before the first shift edge
    assign run = !done_ff && !err_ff;

    always_ff @(posedge clk or negedge lnk.clear_n) begin
        if (!lnk.clear_n) begin
            cnt_ff <= 32'h0;
        end else if (run) begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge lnk.clear_n) begin
        if (!lnk.clear_n) begin
            hdr_ff <= 8'h00;
        end else if (run && cnt_ff < `PSCS_HDR_BITS) begin
            hdr_ff <= {hdr_ff[6:0], din};
        end
    end

    always_ff @(posedge clk or negedge lnk.clear_n) begin
        if (!lnk.clear_n) begin
            err_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (run) begin
            if (cnt_ff == `PSCS_HDR_BITS && hdr_ff != `PSCS_PREAMBLE) begin
                err_ff <= 1'b1;
            end else if (cnt_ff + 32'h1 == lnk.image_bits) begin
                done_ff <= 1'b1;
            end
        end
    end

    assign lnk.done = done_ff;
    assign lnk.err = err_ff;

    property p_sample;
        @(posedge clk) disable iff (!lnk.clear_n)
        (run && cnt_ff < `PSCS_HDR_BITS) |=> hdr_ff[0] == $past(din);
    endproperty
    a_sample: assert property (p_sample) else $error("bit not sampled");

    property p_done_at_len;
        @(posedge clk) disable iff (!lnk.clear_n)
        (run && cnt_ff > `PSCS_HDR_BITS && cnt_ff + 32'h1 == lnk.image_bits)
        |=> done_ff && $stable(cnt_ff + 32'h0) == 1'b0;
    endproperty
    a_done_at_len: assert property (p_done_at_len)
        else $error("done not raised at image end");
endmodule

/* design/pscs_top.sv */
// Passive serial configuration slave: stages, pins and register access
//
// Operation
// - with delay select low, power-on reset lasts between 100 ms and 300 ms.
// - with delay select high, power-on reset lasts between 4 ms and 12 ms.
// - power-on reset drives status low; user I/O stay tri-stated until user mode.
// - weak pull input low enables pull-ups from the end of power-on reset until user mode; high disables.
// - stay in reset stage while request or status line is low.
// - request high releases the open-drain status output.
// - after status is released, enter configuration and accept bits.
// - host clocks until done is high; device raises done on full image.
// - cable mode ignores the user start-up clock option during initialization.
// - chain enable out feeds next device's chain enable in.
// - shared done line makes all chained devices enter user mode together.
// - shared status line low stops configuration of the whole chain.
// - each data bit is sampled on the rising shift clock edge.
// - done line held low from power-up through configuration.
// - a detected error drives status low, returning the chain to reset.
`timescale 1ns/1ps
`include "pscs_consts.svh"
module pscs_top
    import pscs_pkg::*;
#(
    parameter int unsigned POR_STD_CYCLES = `PSCS_POR_STD_CYCLES,
    parameter int unsigned POR_FAST_CYCLES = `PSCS_POR_FAST_CYCLES,
    parameter int unsigned USR_EDGES = `PSCS_USR_EDGES
) (
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Configuration link
    input wire logic CONFIG_SHIFT_CLOCK,
    input wire logic SERIAL_CONFIG_IN,
    input wire logic CONFIG_REQUEST_N,
    input wire logic CONFIG_STATUS_N_IN,
    output logic CONFIG_STATUS_N_OUT,
    output logic CONFIG_STATUS_N_OE,
    input wire logic LOAD_COMPLETE_IN,
    output logic LOAD_COMPLETE_OUT,
    output logic LOAD_COMPLETE_OE,
    // Chain and straps
    input wire logic CHAIN_ENABLE_IN_N,
    output logic CHAIN_ENABLE_OUT_N,
    input wire logic POR_DELAY_SELECT,
    input wire logic WEAK_PULL_ENABLE_N,
    input wire logic USER_STARTUP_CLOCK,
    // User I/O control
    output logic USER_IO_TRISTATE,
    output logic WEAK_PULLUP_ON
);
    pscs_link_if lnk ();

    pscs_state_t state_ff;
    pscs_state_t nxt_state;
    logic [8:0] sync_a_ff;
    logic [8:0] sync_b_ff;
    logic usr_prev_ff;
    logic req_n_s, stat_n_s, load_s, sel_s, pull_n_s, ce_n_s, usr_s;
    logic done_s, err_s, usr_edge;
    logic [23:0] por_cnt_ff;
    logic [23:0] por_limit;
    logic [13:0] init_cnt_ff;
    logic [13:0] init_limit;
    logic init_ok, use_usr;
    logic status_oe_ff, load_oe_ff, tristate_ff, pull_ff, chain_n_ff;
    logic clr_n_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] image_ff;
    logic err_seen_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] rdata_ff;
    logic take;
    logic [31:0] status_word;

    // Pin and link-domain inputs pass two flops
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_a_ff <= 9'h03b;
            sync_b_ff <= 9'h03b;
            usr_prev_ff <= 1'b0;
        end else if (CLK_EN) begin
            sync_a_ff <= {lnk.err, lnk.done, USER_STARTUP_CLOCK,
                CHAIN_ENABLE_IN_N, WEAK_PULL_ENABLE_N, POR_DELAY_SELECT,
                LOAD_COMPLETE_IN, CONFIG_STATUS_N_IN, CONFIG_REQUEST_N};
            sync_b_ff <= sync_a_ff;
            usr_prev_ff <= sync_b_ff[6];
        end
    end

    assign req_n_s = sync_b_ff[0];
    assign stat_n_s = sync_b_ff[1];
    assign load_s = sync_b_ff[2];
    assign sel_s = sync_b_ff[3];
    assign pull_n_s = sync_b_ff[4];
    assign ce_n_s = sync_b_ff[5];
    assign usr_s = sync_b_ff[6];
    assign done_s = sync_b_ff[7];
    assign err_s = sync_b_ff[8];
    assign usr_edge = usr_s && !usr_prev_ff;

    // Power-on delay chosen by the select strap
    assign por_limit = sel_s ? 24'(POR_FAST_CYCLES)
                             : 24'(POR_STD_CYCLES);

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            por_cnt_ff <= 24'h000000;
        end else if (CLK_EN && state_ff == ST_POR) begin
            por_cnt_ff <= por_cnt_ff + 24'h000001;
        end
    end

    // Start-up clock option only counts when not loaded by cable
    assign use_usr = ctrl_ff[`PSCS_CTRL_USRCLK] && !ctrl_ff[`PSCS_CTRL_CABLE];
    assign init_limit = use_usr ? 14'(USR_EDGES)
                                : 14'(`PSCS_INIT_CYCLES);
    assign init_ok = init_cnt_ff >= init_limit;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            init_cnt_ff <= 14'h0000;
        end else if (CLK_EN) begin
            if (state_ff != ST_INIT) begin
                init_cnt_ff <= 14'h0000;
            end else if (load_s && !init_ok && (!use_usr || usr_edge)) begin
                init_cnt_ff <= init_cnt_ff + 14'h0001;
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POR: begin
                if (por_cnt_ff >= por_limit - 24'h000001) begin
                    nxt_state = ST_RESET;
                end
            end
            ST_RESET: begin
                if (req_n_s && stat_n_s) begin
                    nxt_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (!req_n_s) begin
                    nxt_state = ST_RESET;
                end else if (err_s) begin
                    nxt_state = ST_ERROR;
                end else if (!stat_n_s) begin
                    nxt_state = ST_RESET;
                end else if (done_s) begin
                    nxt_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (!req_n_s || !stat_n_s) begin
                    nxt_state = ST_RESET;
                end else if (init_ok && load_s) begin
                    nxt_state = ST_USER;
                end
            end
            ST_USER: begin
                if (!req_n_s) begin
                    nxt_state = ST_RESET;
                end
            end
            ST_ERROR: begin
                if (!req_n_s) begin
                    nxt_state = ST_RESET;
                end
            end
            default: nxt_state = ST_POR;
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= ST_POR;
        end else if (CLK_EN) begin
            state_ff <= nxt_state;
        end
    end

    // Pin drivers follow the coming stage
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_oe_ff <= 1'b1;
            load_oe_ff <= 1'b1;
            tristate_ff <= 1'b1;
            pull_ff <= 1'b0;
            chain_n_ff <= 1'b1;
            clr_n_ff <= 1'b0;
        end else if (CLK_EN) begin
            status_oe_ff <= nxt_state == ST_POR || nxt_state == ST_ERROR ||
                (nxt_state == ST_RESET && !req_n_s);
            load_oe_ff <= nxt_state != ST_INIT && nxt_state != ST_USER;
            tristate_ff <= nxt_state != ST_USER;
            pull_ff <= !pull_n_s && nxt_state != ST_POR &&
                nxt_state != ST_USER;
            chain_n_ff <= nxt_state != ST_INIT && nxt_state != ST_USER;
            clr_n_ff <= nxt_state == ST_CONFIG && !ce_n_s;
        end
    end

    assign CONFIG_STATUS_N_OUT = 1'b0;
    assign CONFIG_STATUS_N_OE = status_oe_ff;
    assign LOAD_COMPLETE_OUT = 1'b0;
    assign LOAD_COMPLETE_OE = load_oe_ff;
    assign CHAIN_ENABLE_OUT_N = chain_n_ff;
    assign USER_IO_TRISTATE = tristate_ff;
    assign WEAK_PULLUP_ON = pull_ff;

    // Image length is quasi-static: software writes it outside configuration
    assign lnk.clear_n = clr_n_ff;
    assign lnk.image_bits = image_ff;

    pscs_shift pscs_shift_inst (
        .clk(CONFIG_SHIFT_CLOCK),
        .din(SERIAL_CONFIG_IN),
        .lnk(lnk.link)
    );

    // Register access, zero wait states
    assign take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign status_word = {23'h0, err_seen_ff, 2'h0, state_ff};

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0;
        end else if (CLK_EN) begin
            wr_pend_ff <= take && HWRITE;
            wr_addr_ff <= HADDR[7:0];
            if (take && !HWRITE) begin
                if (HADDR[31:0] == {24'h0, `PSCS_OFS_CTRL}) begin
                    rdata_ff <= ctrl_ff;
                end else if (HADDR[31:0] == {24'h0, `PSCS_OFS_IMAGE}) begin
                    rdata_ff <= image_ff;
                end else if (HADDR[31:0] == {24'h0, `PSCS_OFS_STATUS}) begin
                    rdata_ff <= status_word;
                end else begin
                    rdata_ff <= 32'h0;
                end
            end
        end
    end

    assign HRDATA = rdata_ff;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_ff <= `PSCS_CTRL_RST;
            image_ff <= `PSCS_IMAGE_RST;
        end else if (CLK_EN && wr_pend_ff) begin
            if (wr_addr_ff == `PSCS_OFS_CTRL) begin
                ctrl_ff <= {30'h0, HWDATA[1:0]};
            end else if (wr_addr_ff == `PSCS_OFS_IMAGE) begin
                image_ff <= HWDATA;
            end
        end
    end

    // Sticky error flag: a new error wins over a clear
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            err_seen_ff <= 1'b0;
        end else if (CLK_EN) begin
            if (state_ff == ST_CONFIG && err_s) begin
                err_seen_ff <= 1'b1;
            end else if (wr_pend_ff && wr_addr_ff == `PSCS_OFS_STATUS &&
                    HWDATA[`PSCS_STAT_ERR]) begin
                err_seen_ff <= 1'b0;
            end
        end
    end

    property p_por_status;
        @(posedge CLOCK) disable iff (!ARST_N)
        state_ff == ST_POR |-> CONFIG_STATUS_N_OE && USER_IO_TRISTATE;
    endproperty
    a_por_status: assert property (p_por_status)
        else $error("status not driven low during power-on reset");

    property p_por_len;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_POR && CLK_EN && por_cnt_ff + 24'h000001 < por_limit)
        |=> state_ff == ST_POR;
    endproperty
    a_por_len: assert property (p_por_len)
        else $error("power-on reset left early");

    property p_io_tristate;
        @(posedge CLOCK) disable iff (!ARST_N)
        state_ff != ST_USER |-> USER_IO_TRISTATE;
    endproperty
    a_io_tristate: assert property (p_io_tristate)
        else $error("user I/O driven before user mode");

    property p_reset_hold;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_RESET && CLK_EN && !(req_n_s && stat_n_s))
        |=> state_ff == ST_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset stage left while a line is low");

    property p_release;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_RESET && CLK_EN && req_n_s)
        |=> !CONFIG_STATUS_N_OE;
    endproperty
    a_release: assert property (p_release)
        else $error("status not released after request high");

    property p_enter_cfg;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_RESET && CLK_EN && req_n_s && stat_n_s)
        |=> state_ff == ST_CONFIG && ($past(ce_n_s) || lnk.clear_n);
    endproperty
    a_enter_cfg: assert property (p_enter_cfg)
        else $error("configuration stage not entered");

    property p_done_low;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_POR || state_ff == ST_RESET || state_ff == ST_CONFIG)
        |-> LOAD_COMPLETE_OE;
    endproperty
    a_done_low: assert property (p_done_low)
        else $error("done line released too early");

    property p_err_drive;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_CONFIG && CLK_EN && req_n_s && err_s)
        |=> state_ff == ST_ERROR && CONFIG_STATUS_N_OE;
    endproperty
    a_err_drive: assert property (p_err_drive)
        else $error("error did not pull status low");

    property p_chain_stop;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_CONFIG && CLK_EN && req_n_s && !err_s && !stat_n_s)
        |=> state_ff == ST_RESET;
    endproperty
    a_chain_stop: assert property (p_chain_stop)
        else $error("configuration kept running with status low");

    property p_init_wait;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_INIT && !load_s) |=> state_ff != ST_USER;
    endproperty
    a_init_wait: assert property (p_init_wait)
        else $error("user mode entered while done line low");

    property p_cable_init;
        @(posedge CLOCK) disable iff (!ARST_N)
        (state_ff == ST_INIT && CLK_EN && load_s && req_n_s && stat_n_s &&
            ctrl_ff[`PSCS_CTRL_CABLE] && !init_ok)
        |=> init_cnt_ff == $past(init_cnt_ff) + 14'h0001;
    endproperty
    a_cable_init: assert property (p_cable_init)
        else $error("cable initialization waited for start-up clock");

    property p_pull;
        @(posedge CLOCK) disable iff (!ARST_N)
        WEAK_PULLUP_ON |-> state_ff != ST_POR && $past(!pull_n_s);
    endproperty
    a_pull: assert property (p_pull)
        else $error("weak pull-up on against control input");

    c_user: cover property (@(posedge CLOCK) disable iff (!ARST_N)
        state_ff == ST_INIT ##1 state_ff == ST_USER);
    c_error: cover property (@(posedge CLOCK) disable iff (!ARST_N)
        state_ff == ST_CONFIG ##1 state_ff == ST_ERROR);
    c_chain_abort: cover property (@(posedge CLOCK) disable iff (!ARST_N)
        state_ff == ST_CONFIG ##1 state_ff == ST_RESET);
endmodule

/* dv/pscs_host.sv */
// Behavioural configuration host driving the serial load pins
`timescale 1ns/1ps
module pscs_host (
    // Serial load pins
    output logic shift_clk,
    output logic data,
    output logic req_n,
    // Shared open-drain wires
    input wire logic status_w,
    input wire logic done_w
);
    initial begin
        shift_clk = 1'b0;
        data = 1'b1;
        req_n = 1'b0;
    end

    // Low pulse, rising edge, then wait for the status release
    task automatic start();
        req_n = 1'b0;
        #2000;
        req_n = 1'b1;
        wait (status_w === 1'b1);
        #2100;
    endtask

    task automatic hold_low();
        req_n = 1'b0;
    endtask

    // MSB first; clock idles low and data is driven back high after each load
    task automatic send(input logic [15:0] img);
        #7;
        for (int i = 15; i >= 0; i--) begin
            if (done_w === 1'b1) break;
            data = img[i];
            #40 shift_clk = 1'b1;
            #40 shift_clk = 1'b0;
        end
        data = 1'b1;
    endtask
endmodule

/* dv/pscs_top_tb_top.sv */
// Self-checking bench for the configuration slave
`timescale 1ns/1ps
`include "pscs_consts.svh"
module pscs_top_tb_top;
    import pscs_pkg::*;
    localparam int unsigned STD = 200;
    localparam int unsigned FAST = 50;
    logic clk, arst_n, hsel, hwrite, por_sel, pull_n, chain_n;
    logic oth_st, oth_dn;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata;
    logic [31:0] hrdata;
    logic hready, hresp, st_oe, st_out, ld_oe, ld_out, ceo_n;
    logic tri_io, pull_on, sclk, sdin, req_n, clk_en, usr_clk;
    int fail_count, num_checks;
    // Wired-and levels of the shared pulled-up lines
    wire status_w = (st_oe ? st_out : 1'b1) && !oth_st;
    wire done_w = (ld_oe ? ld_out : 1'b1) && !oth_dn;

    pscs_top #(.POR_STD_CYCLES(STD), .POR_FAST_CYCLES(FAST), .USR_EDGES(20))
    pscs_top_inst (
        .CLOCK(clk), .ARST_N(arst_n), .CLK_EN(clk_en),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp),
        .CONFIG_SHIFT_CLOCK(sclk), .SERIAL_CONFIG_IN(sdin),
        .CONFIG_REQUEST_N(req_n), .CONFIG_STATUS_N_IN(status_w),
        .CONFIG_STATUS_N_OUT(st_out), .CONFIG_STATUS_N_OE(st_oe),
        .LOAD_COMPLETE_IN(done_w), .LOAD_COMPLETE_OUT(ld_out),
        .LOAD_COMPLETE_OE(ld_oe), .CHAIN_ENABLE_IN_N(chain_n),
        .CHAIN_ENABLE_OUT_N(ceo_n), .POR_DELAY_SELECT(por_sel),
        .WEAK_PULL_ENABLE_N(pull_n), .USER_STARTUP_CLOCK(usr_clk),
        .USER_IO_TRISTATE(tri_io), .WEAK_PULLUP_ON(pull_on)
    );

    pscs_host pscs_host_inst (
        .shift_clk(sclk), .data(sdin), .req_n(req_n),
        .status_w(status_w), .done_w(done_w)
    );

    always #10 clk = ~clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Pin values are taken when the task is called; only the compare waits for mid-cycle
    task automatic check_pin(input logic got, input logic exp);
        @(negedge clk);
        check({31'h0, got}, {31'h0, exp});
    endtask

    task automatic ahb_xfer(input logic [7:0] a, input logic w,
                            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb_xfer(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb_xfer(a, 1'b0, 32'h0, r);
        check(r, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    // Reset, then the stage must still be power-on at lo and reset at hi
    task automatic power_up(input logic sel, input logic pn,
                            input int lo, input int hi);
        arst_n <= 1'b0;
        por_sel <= sel;
        pull_n <= pn;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        check_pin(st_oe, 1'b1);
        check_pin(ld_oe, 1'b1);
        check_pin(tri_io, 1'b1);
        check_pin(pull_on, 1'b0);
        repeat (lo) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h01);
        repeat (hi - lo) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h02);
        check_pin(pull_on, !pn);
        $display("test power_up sel %0b done", sel);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial begin
        {clk, hsel, hwrite, oth_st, oth_dn, chain_n} = '0;
        {arst_n, por_sel, pull_n} = '0;
        {clk_en, usr_clk} = 2'b10;
        hsize = 3'h2;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        fail_count = 0;
        num_checks = 0;
        @(posedge clk);
        power_up(1'b1, 1'b1, FAST / 2 - 5, FAST * 3 / 2);
        power_up(1'b0, 1'b0, STD / 2 - 5, STD * 3 / 2);
        rd_chk(`PSCS_OFS_CTRL, `PSCS_CTRL_RST);
        rd_chk(`PSCS_OFS_IMAGE, `PSCS_IMAGE_RST);
        ahb_wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        ahb_wr(`PSCS_OFS_STATUS, 32'h0000_003f);
        rd_chk(`PSCS_OFS_STATUS, 32'h02);
        ahb_wr(`PSCS_OFS_CTRL, 32'h3);
        ahb_wr(`PSCS_OFS_IMAGE, 32'h10);
        rd_chk(`PSCS_OFS_CTRL, 32'h3);
        $display("test registers done");
        oth_dn <= 1'b1;
        pscs_host_inst.start();
        rd_chk(`PSCS_OFS_STATUS, 32'h04);
        check_pin(st_oe, 1'b0);
        check_pin(ld_oe, 1'b1);
        check_pin(ceo_n, 1'b1);
        pscs_host_inst.send(16'ha53c);
        repeat (20) @(posedge clk);
        check_pin(ld_oe, 1'b0);
        check_pin(ceo_n, 1'b0);
        rd_chk(`PSCS_OFS_STATUS, 32'h08);
        repeat (300) @(posedge clk);
        check_pin(tri_io, 1'b1);
        oth_dn <= 1'b0;
        repeat (2700) @(posedge clk);
        check_pin(tri_io, 1'b1);
        repeat (100) @(posedge clk);
        check_pin(tri_io, 1'b0);
        rd_chk(`PSCS_OFS_STATUS, 32'h10);
        $display("test full_load done");
        pscs_host_inst.hold_low();
        repeat (10) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h02);
        check_pin(st_oe, 1'b1);
        check_pin(ld_oe, 1'b1);
        chain_n <= 1'b1;
        pscs_host_inst.start();
        pscs_host_inst.send(16'ha53c);
        repeat (20) @(posedge clk);
        check_pin(ld_oe, 1'b1);
        rd_chk(`PSCS_OFS_STATUS, 32'h04);
        oth_st <= 1'b1;
        repeat (10) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h02);
        oth_st <= 1'b0;
        chain_n <= 1'b0;
        repeat (120) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h04);
        pscs_host_inst.send(16'h5a00);
        repeat (20) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h120);
        check_pin(st_oe, 1'b1);
        pscs_host_inst.start();
        ahb_wr(`PSCS_OFS_STATUS, 32'h100);
        rd_chk(`PSCS_OFS_STATUS, 32'h04);
        $display("test chain_error done");
        ahb_wr(`PSCS_OFS_CTRL, 32'h2);
        pscs_host_inst.send(16'ha53c);
        repeat (100) @(posedge clk);
        check_pin(tri_io, 1'b1);
        rd_chk(`PSCS_OFS_STATUS, 32'h08);
        repeat (48) begin
            repeat (2) @(posedge clk);
            usr_clk <= ~usr_clk;
        end
        repeat (10) @(posedge clk);
        rd_chk(`PSCS_OFS_STATUS, 32'h10);
        clk_en <= 1'b0;
        pscs_host_inst.hold_low();
        repeat (20) @(posedge clk);
        check_pin(tri_io, 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (10) @(posedge clk);
        check_pin(tri_io, 1'b1);
        rd_chk(`PSCS_OFS_STATUS, 32'h02);
        $display("test user_clock done");
        summarize();
    end
endmodule
